// file: nvsr_host.sv
// host controller issuing six-read command sequences to the memory
module nvsr_host
  import nvsr_pkg::*;
#(
  parameter int SAVE_CYC    = 1250000,
  parameter int RESTORE_CYC = 25000
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // user command port
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  output logic                   cmd_ready,
  output logic                   cmd_done,
  output logic [DATA_W-1:0]      cmd_rdata,
  // device pins
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   write_n,
  output logic [ADDR_W-1:0]      addr,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              store_busy_n
);
  // ***********************************
  // state and registers
  // ***********************************
  nvsr_state_type    state_ff;
  nvsr_state_type    nxt_state;
  logic [2:0]        step_ff;
  logic [2:0]        nxt_step;
  logic [1:0]        op_ff;
  logic              busy_seen_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              done_ff;
  logic              load;
  logic [CNT_W-1:0]  load_val;
  logic              tdone;
  // ***********************************
  // address selection
  // ***********************************
  logic [SEQ_W-1:0] cmd_addr;
  logic [SEQ_W-1:0] step_addr;
  logic             last_step;
  logic             waits_busy;
  logic             busy_low;
  logic             busy_ok;
  assign cmd_addr = (op_ff == OP_SAVE)    ? CMD_SAVE :
                    (op_ff == OP_RESTORE) ? CMD_RESTORE :
                    (op_ff == OP_PLS_OFF) ? CMD_PLS_OFF :
                                            CMD_PLS_ON;
  assign step_addr = (step_ff == 3'h0) ? SEQ_A1 :
                     (step_ff == 3'h1) ? SEQ_A2 :
                     (step_ff == 3'h2) ? SEQ_A3 :
                     (step_ff == 3'h3) ? SEQ_A4 :
                     (step_ff == 3'h4) ? SEQ_A5 : cmd_addr;
  assign last_step  = (step_ff == LAST_STEP);
  assign waits_busy = (op_ff == OP_SAVE) || (op_ff == OP_RESTORE);
  assign busy_low   = !store_busy_n;
  // a save must have shown busy before it may end
  assign busy_ok    = store_busy_n && (busy_seen_ff || (op_ff != OP_SAVE));
  assign cmd_ready  = (state_ff == NVSR_IDLE) && store_busy_n;
  assign cmd_done   = done_ff;
  assign cmd_rdata  = rdata_ff;
  // ***********************************
  // pin drive
  // ***********************************
  logic in_pulse;
  assign in_pulse   = (state_ff == NVSR_PULSE);
  assign chip_sel_n = !((state_ff == NVSR_SETUP) || in_pulse);
  assign out_en_n   = !in_pulse;
  assign write_n    = 1'b1;
  // top bit held low, only low bits decoded
  assign addr = {1'b0, step_addr};
  // ***********************************
  // sequencer
  // ***********************************
  always_comb begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    load      = 1'b0;
    load_val  = '0;
    case (state_ff)
      NVSR_IDLE: begin
        if (cmd_valid && store_busy_n) begin
          nxt_state = NVSR_SETUP;
          nxt_step  = 3'h0;
          load      = 1'b1;
          load_val  = CNT_W'(1);
        end
      end
      NVSR_SETUP: begin
        if (tdone) begin
          nxt_state = NVSR_PULSE;
          load      = 1'b1;
          load_val  = CNT_W'(RD_CYC);
        end
      end
      NVSR_PULSE: begin
        if (tdone) begin
          load     = 1'b1;
          load_val = CNT_W'(1);
          if (last_step && waits_busy) begin
            nxt_state = NVSR_BUSY;
            load_val  = (op_ff == OP_SAVE) ? CNT_W'(SAVE_CYC)
                                           : CNT_W'(RESTORE_CYC);
          end else if (last_step) begin
            nxt_state = NVSR_HOLD;
            load_val  = CNT_W'(HOLDOFF_CYC);
          end else begin
            nxt_state = NVSR_GAP;
          end
        end
      end
      NVSR_GAP: begin
        if (tdone) begin
          nxt_state = NVSR_SETUP;
          nxt_step  = step_ff + 3'h1;
          load      = 1'b1;
          load_val  = CNT_W'(1);
        end
      end
      NVSR_BUSY: begin
        // no access until save or restore ends
        if (tdone && busy_ok) begin
          nxt_state = NVSR_HOLD;
          load      = 1'b1;
          load_val  = CNT_W'(HOLDOFF_CYC);
        end
      end
      NVSR_HOLD: begin
        if (tdone) begin
          nxt_state = NVSR_IDLE;
        end
      end
      default: begin
        nxt_state = NVSR_IDLE;
      end
    endcase
  end
  // ***********************************
  // registers
  // ***********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= NVSR_IDLE;
      step_ff  <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      step_ff  <= nxt_step;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_ff <= OP_SAVE;
    end else if (cmd_ready && cmd_valid) begin
      op_ff <= cmd_op;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (in_pulse && tdone) begin
      rdata_ff <= dq_in;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_seen_ff <= 1'b0;
    end else begin
      busy_seen_ff <= (state_ff == NVSR_BUSY) && (busy_seen_ff || busy_low);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == NVSR_HOLD) && tdone;
    end
  end
  // ***********************************
  // timer
  // ***********************************
  nvsr_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (load),
    .value   (load_val),
    .done    (tdone)
  );
endmodule : nvsr_host

// file: nvsr_pkg.sv
// constants and types for the nonvolatile sequence host controller
// How it works
// - host issues six reads; first three at 0x0E38, 0x31C7, 0x03E0
// - host reads 0x3C1F then 0x303F; sixth address picks the command
// - host keeps write strobe high through all six reads
// - enable change persists only after a later save; host issues one only on a save command
package nvsr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_W  = 14;
  localparam logic [SEQ_W-1:0] SEQ_A1 = 14'h0E38;
  localparam logic [SEQ_W-1:0] SEQ_A2 = 14'h31C7;
  localparam logic [SEQ_W-1:0] SEQ_A3 = 14'h03E0;
  localparam logic [SEQ_W-1:0] SEQ_A4 = 14'h3C1F;
  localparam logic [SEQ_W-1:0] SEQ_A5 = 14'h303F;
  localparam logic [SEQ_W-1:0] CMD_SAVE    = 14'h0FC0;
  localparam logic [SEQ_W-1:0] CMD_RESTORE = 14'h0C63;
  localparam logic [SEQ_W-1:0] CMD_PLS_OFF = 14'h0B45;
  localparam logic [SEQ_W-1:0] CMD_PLS_ON  = 14'h0B46;
  localparam logic [1:0] OP_SAVE    = 2'h0;
  localparam logic [1:0] OP_RESTORE = 2'h1;
  localparam logic [1:0] OP_PLS_OFF = 2'h2;
  localparam logic [1:0] OP_PLS_ON  = 2'h3;
  localparam int CLK_NS       = 8;
  localparam int RD_CYC_NS    = 48;
  localparam int RD_CYC       = (RD_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLDOFF_NS   = 24;
  localparam int HOLDOFF_CYC  = (HOLDOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 21;
  localparam logic [2:0] LAST_STEP = 3'h5;
  typedef enum logic [5:0] {
    NVSR_IDLE  = 6'h01,
    NVSR_SETUP = 6'h02,
    NVSR_PULSE = 6'h04,
    NVSR_GAP   = 6'h08,
    NVSR_BUSY  = 6'h10,
    NVSR_HOLD  = 6'h20
  } nvsr_state_type;
endpackage : nvsr_pkg

// file: nvsr_timer.sv
// down counter that times pulses and busy waits
module nvsr_timer
  import nvsr_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  // status
  output logic                  done
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  assign nxt_cnt = load ? value :
                   (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign done = (cnt_ff == '0);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : nvsr_timer

// file: nvsr_host_assertions.sv
// concurrent checks on the host controller ports
module nvsr_host_chk
  import nvsr_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cmd_valid,
  input wire logic [1:0]        cmd_op,
  input wire logic              cmd_ready,
  input wire logic              cmd_done,
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              write_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              store_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_write_kept_high: assert property (write_n)
    else $error("write strobe low");
  a_first_address: assert property (cmd_valid && cmd_ready |=>
    !chip_sel_n && addr[SEQ_W-1:0] == SEQ_A1) else $error("bad first addr");
  a_second_address: assert property ($rose(out_en_n) &&
    addr[SEQ_W-1:0] == SEQ_A1 |-> ##[1:20] (!out_en_n &&
    addr[SEQ_W-1:0] == SEQ_A2)) else $error("bad second addr");
  a_fifth_address: assert property ($rose(out_en_n) &&
    addr[SEQ_W-1:0] == SEQ_A4 |-> ##[1:20] (!out_en_n &&
    addr[SEQ_W-1:0] == SEQ_A5)) else $error("bad fifth addr");
  a_top_bit_zero: assert property (!chip_sel_n |-> !addr[ADDR_W-1])
    else $error("top address bit set");
  a_pulse_width: assert property ($fell(out_en_n) |->
    (!out_en_n)[*7] ##1 out_en_n) else $error("read pulse width");
  a_busy_pins_idle: assert property (!store_busy_n |->
    chip_sel_n && out_en_n) else $error("access while busy");
  a_busy_refuses: assert property (!store_busy_n |->
    !cmd_ready && !cmd_done) else $error("ready or done while busy");
  a_holdoff_wait: assert property ($rose(store_busy_n) |->
    (!cmd_done)[*3]) else $error("done inside holdoff");
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done too long");
  c_save: cover property (cmd_valid && cmd_ready && cmd_op == OP_SAVE);
  c_refused: cover property (cmd_valid && !cmd_ready);
  c_busy_end: cover property ($rose(store_busy_n));
endmodule : nvsr_host_chk

// file: nvsr_mem_model.sv
// behavioural memory with shadow cells and six-read command decoding
module nvsr_mem_model
  import nvsr_pkg::*;
#(
  parameter int BUSY_CYC = 30,
  parameter int REC_CYC  = 12,
  parameter int PUR_CYC  = 60
)
(
  // host pins
  input  wire logic              clk,
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              write_n,
  input  wire logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0]      dq_in,
  output logic                   store_busy_n,
  // observation
  output logic                   pls_en,
  output logic [7:0]             saves,
  output logic [7:0]             restores
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] arr_ff, nv_ff;
  logic [SEQ_W-1:0]  a_ff;
  logic [2:0]        step_ff;
  logic              oe_ff, hsb_ff;
  int                busy_cnt;
  wire [SEQ_W-1:0] want = step_ff == 3'h0 ? SEQ_A1 : step_ff == 3'h1 ?
    SEQ_A2 : step_ff == 3'h2 ? SEQ_A3 : step_ff == 3'h3 ? SEQ_A4 : SEQ_A5;
  wire rd_end = out_en_n && !oe_ff && busy_cnt == 0;
  wire sixth = step_ff == LAST_STEP;
  wire hi_z = sixth && (addr[SEQ_W-1:0] == CMD_SAVE ||
    addr[SEQ_W-1:0] == CMD_RESTORE);
  wire rd_on = !chip_sel_n && !out_en_n && write_n && busy_cnt == 0;
  assign store_busy_n = !(busy_cnt != 0 && hsb_ff);
  initial begin
    {dq_in, saves, restores, step_ff, oe_ff, a_ff} = '0;
    arr_ff = 8'h5A;
    nv_ff = 8'h00;
    pls_en = 1'b1;
    hsb_ff = 1'b1;
    busy_cnt = PUR_CYC;
  end
  always @(posedge clk) begin
    oe_ff <= out_en_n;
    if (!out_en_n) a_ff <= addr[SEQ_W-1:0];
    dq_in <= (rd_on && !hi_z) ? addr[7:0] ^ arr_ff : ~dq_in;
    if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) arr_ff <= nv_ff;
    end else if (!chip_sel_n && !write_n) step_ff <= 3'h0;
    else if (rd_end && !sixth && a_ff != want) step_ff <= 3'h0;
    else if (rd_end && !sixth) step_ff <= step_ff + 3'h1;
    else if (rd_end) begin
      step_ff <= 3'h0;
      hsb_ff <= a_ff == CMD_SAVE;
      if (a_ff == CMD_SAVE) nv_ff <= arr_ff;
      if (a_ff == CMD_SAVE) busy_cnt <= BUSY_CYC;
      if (a_ff == CMD_RESTORE) arr_ff <= 8'h00;
      if (a_ff == CMD_RESTORE) busy_cnt <= REC_CYC;
      saves <= saves + {7'h0, a_ff == CMD_SAVE};
      restores <= restores + {7'h0, a_ff == CMD_RESTORE};
      if (a_ff == CMD_PLS_OFF) pls_en <= 1'b0;
      if (a_ff == CMD_PLS_ON) pls_en <= 1'b1;
    end
  end
endmodule : nvsr_mem_model

// file: nvsr_host_tb.sv
// testbench for the six-read command host controller
module nvsr_host_tb
  import nvsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic cmd_ready, cmd_done, chip_sel_n, out_en_n, write_n, store_busy_n;
  logic pls_en;
  logic [7:0] cmd_rdata, dq_in, saves, restores;
  logic [ADDR_W-1:0] addr;
  int miscompares = 0, samples_checked = 0, cyc;
  nvsr_host #(.SAVE_CYC(20), .RESTORE_CYC(20)) nvsr_host_i (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
    .addr(addr), .dq_in(dq_in), .store_busy_n(store_busy_n));
  nvsr_mem_model nvsr_mem_model_i (.clk(clk), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_n(write_n), .addr(addr), .dq_in(dq_in),
    .store_busy_n(store_busy_n), .pls_en(pls_en), .saves(saves),
    .restores(restores));
  initial forever #4 clk = ~clk;
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic run_cmd(input logic [1:0] op);
    cyc = 0;
    @(posedge clk);
    cmd_op <= op;
    cmd_valid <= 1'b1;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (cmd_done !== 1'b1 && cyc < 2000) begin
      @(negedge clk);
      cyc++;
    end
    check_val({7'h0, cyc < 2000}, 8'h01);
  endtask : run_cmd
  task automatic t_powerup_off;
    @(negedge clk);
    check_val({7'h0, store_busy_n}, 8'h00);
    check_val({7'h0, cmd_ready}, 8'h00);
    run_cmd(OP_PLS_OFF);
    check_val({7'h0, pls_en}, 8'h00);
    check_val(cmd_rdata, 8'h45);
  endtask : t_powerup_off
  task automatic t_on_then_save;
    run_cmd(OP_PLS_ON);
    check_val({7'h0, pls_en}, 8'h01);
    check_val(cmd_rdata, 8'h46);
    run_cmd(OP_SAVE);
    check_val(saves, 8'h01);
    check_val({7'h0, cyc > 94}, 8'h01);
  endtask : t_on_then_save
  task automatic t_restore;
    run_cmd(OP_RESTORE);
    check_val(restores, 8'h01);
    run_cmd(OP_PLS_OFF);
    check_val(cmd_rdata, 8'h45);
  endtask : t_restore
  initial begin
    #40000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_powerup_off();
    t_on_then_save();
    t_restore();
    finish_test();
  end
endmodule : nvsr_host_tb
bind nvsr_host nvsr_host_chk nvsr_host_chk_i (.clk(clk), .sys_rst(sys_rst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
  .cmd_done(cmd_done), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .write_n(write_n), .addr(addr), .store_busy_n(store_busy_n));
